// ===== common/fed_pkg.sv
`default_nettype none
// Shared constants and carriers for the escape opcode decoder.
package fed_pkg;
  // Register byte offsets on the APB slave.
  localparam logic [7:0] FED_OFS_WORD = 8'h00;
  localparam logic [7:0] FED_OFS_CTRL = 8'h04;
  localparam logic [7:0] FED_OFS_RESULT = 8'h08;
  // Position of the zero-operand hint in the control register.
  localparam int FED_CTRL_ZERO_BIT = 0;
  // Reset values of the software-visible registers.
  localparam logic [31:0] FED_WORD_RST = 32'h0000_0000;
  localparam logic FED_ZERO_HINT_RST = 1'b0;
  // Five-bit escape prefix that opens every coprocessor instruction.
  localparam logic [4:0] FED_ESC_PREFIX = 5'h1b;
  // Memory operand formats.
  localparam logic [1:0] FED_MF_REAL32 = 2'h0;
  localparam logic [1:0] FED_MF_INT32 = 2'h1;
  localparam logic [1:0] FED_MF_REAL64 = 2'h2;
  localparam logic [1:0] FED_MF_INT16 = 2'h3;
  // Addressing-kind and locator codes that change the byte count.
  localparam logic [1:0] FED_MOD_NODISP = 2'h0;
  localparam logic [1:0] FED_MOD_DISP8 = 2'h1;
  localparam logic [1:0] FED_MOD_DISP32 = 2'h2;
  localparam logic [1:0] FED_MOD_REG = 2'h3;
  localparam logic [2:0] FED_RM_SIB = 3'h4;
  localparam logic [2:0] FED_RM_DIRECT = 3'h5;
  localparam logic [2:0] FED_SIB_NO_INDEX = 3'h4;
  localparam logic [2:0] FED_SIB_NO_BASE = 3'h5;
  // Instruction byte counts.
  localparam logic [2:0] FED_LEN_BASE = 3'h2;
  localparam logic [2:0] FED_LEN_DISP8 = 3'h1;
  localparam logic [2:0] FED_LEN_DISP32 = 3'h4;
  // Extra execution clocks.
  localparam logic [2:0] FED_EXTRA_BASE_INDEX = 3'h1;
  localparam logic [2:0] FED_EXTRA_ZERO_LOAD = 3'h5;

  // Decoded operation codes.
  typedef enum logic [4:0] {
    FED_OP_UNHANDLED = 5'b00000, FED_OP_LOAD_MEM = 5'b00001,
    FED_OP_LOAD_INT64 = 5'b00010, FED_OP_LOAD_REAL80 = 5'b00011,
    FED_OP_LOAD_BCD = 5'b00100, FED_OP_LOAD_REG = 5'b00101,
    FED_OP_SWAP = 5'b00110, FED_OP_STORE_MEM = 5'b00111,
    FED_OP_STORE_POP_MEM = 5'b01000, FED_OP_STORE_INT64 = 5'b01001,
    FED_OP_STORE_REAL80 = 5'b01010, FED_OP_STORE_BCD = 5'b01011,
    FED_OP_STORE_REG = 5'b01100, FED_OP_STORE_POP_REG = 5'b01101,
    FED_OP_CMP_MEM = 5'b01110, FED_OP_CMP_POP_MEM = 5'b01111,
    FED_OP_CMP_REG = 5'b10000, FED_OP_CMP_POP_REG = 5'b10001,
    FED_OP_CMP_POP2 = 5'b10010, FED_OP_TEST_ZERO = 5'b10011,
    FED_OP_CLASSIFY = 5'b10100, FED_OP_UCMP = 5'b10101,
    FED_OP_UCMP_POP = 5'b10110, FED_OP_UCMP_POP2 = 5'b10111
  } fed_op_t;

  // APB request from the master.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } fed_apb_req_t;

  // APB answer of the slave.
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } fed_apb_rsp_t;

  // Decoded instruction, 30 bits, as handed to the execution unit.
  typedef struct packed {
    logic valid;
    logic not_escape;
    logic unhandled;
    fed_op_t op;
    logic [1:0] mf;
    logic target;
    logic reverse;
    logic unwind;
    logic [2:0] slot;
    logic [1:0] pops;
    logic [1:0] mode;
    logic [2:0] rm;
    logic base_index;
    logic [2:0] length;
    logic [2:0] extra;
  } fed_dec_t;

  // Whole state of the decoder.
  typedef struct packed {
    logic [31:0] word;
    logic zero_hint;
    fed_dec_t dec;
    fed_apb_rsp_t rsp;
  } fed_state_t;
endpackage
`default_nettype wire

// ===== rtl/fed_decoder.sv
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// RL1: Only 11011-prefixed words count as instructions.
// RL2: Format field picks real32, int32, real64, int16.
// RL3: Target bit sends result to top or slot.
// RL4: Swap XOR target sets the operand order.
// RL5: Unwind bit pops once after the operation.
// RL6: Slot field counts down from the top.
// RL7: Addressing fields read exactly like host CPU.
// RL8: Index and offset bytes follow host rules.
// RL9: Recognise all load-to-top and swap forms.
// RL10: Recognise all store and store-pop forms.
// RL11: Recognise compare forms, memory and register.
// RL12: Recognise the three fixed compare/test encodings.
// RL13: Recognise the three unordered compare forms.
// RL14: Base plus index adds one clock.
// RL15: Zero real load from memory adds five.
// RL16: Fields and op appear with word acceptance.
// RL17: Uncovered escape words flagged unhandled, not run.
module fed_decoder (
  input wire logic clk,
  input wire logic srst,
  input wire fed_pkg::fed_apb_req_t apb_req,
  output fed_pkg::fed_apb_rsp_t apb_rsp,
  output fed_pkg::fed_dec_t dec_out
);

  // Registered state and its next value.
  fed_pkg::fed_state_t st_ff;
  fed_pkg::fed_state_t nxt_st;
  // A transfer completes when the slave already shows ready.
  logic acc_w;
  // Completed write to the instruction word register.
  logic wr_word_w;
  // Every check samples on the rising edge and rests during reset.
  default clocking chk_cb @(posedge clk);
  endclocking
  default disable iff (srst);

  // Decodes one instruction word; bits 15:8 are the first byte.
  function automatic fed_pkg::fed_dec_t decode_word(
    input logic [31:0] w,
    input logic zero_hint
  );
    fed_pkg::fed_dec_t d;
    logic is_reg;
    logic has_sib;
    logic subdiv;
    logic zero_load;
    logic [2:0] offset_bytes;
    d = '0;
    d.valid = 1'b1;
    d.not_escape = (w[15:11] != fed_pkg::FED_ESC_PREFIX); // see RL1
    d.mf = w[10:9]; // see RL2
    d.mode = w[7:6]; // see RL7
    d.rm = w[2:0]; // see RL7
    is_reg = (w[7:6] == fed_pkg::FED_MOD_REG);
    d.target = is_reg & w[10]; // see RL3
    d.unwind = is_reg & w[9]; // see RL5
    d.slot = is_reg ? w[2:0] : 3'h0; // see RL6
    // Subtract and divide carry the swap flag in the low bit of part b.
    subdiv = ~w[8] & (is_reg ? (w[7:5] == 3'h7) : w[5]);
    d.op = fed_pkg::FED_OP_UNHANDLED;
    if (!d.not_escape) begin
      if (!is_reg) begin
        // Specific first-byte forms are listed before the format forms.
        casez ({w[10:8], w[5:3]})
          6'b111101: d.op = fed_pkg::FED_OP_LOAD_INT64; // see RL9
          6'b011101: d.op = fed_pkg::FED_OP_LOAD_REAL80; // see RL9
          6'b111100: d.op = fed_pkg::FED_OP_LOAD_BCD; // see RL9
          6'b111111: d.op = fed_pkg::FED_OP_STORE_INT64; // see RL10
          6'b011111: d.op = fed_pkg::FED_OP_STORE_REAL80; // see RL10
          6'b111110: d.op = fed_pkg::FED_OP_STORE_BCD; // see RL10
          6'b??1000: d.op = fed_pkg::FED_OP_LOAD_MEM; // see RL9
          6'b??1010: d.op = fed_pkg::FED_OP_STORE_MEM; // see RL10
          6'b??1011: d.op = fed_pkg::FED_OP_STORE_POP_MEM; // see RL10
          6'b??0010: d.op = fed_pkg::FED_OP_CMP_MEM; // see RL11
          6'b??0011: d.op = fed_pkg::FED_OP_CMP_POP_MEM; // see RL11
          default: d.op = fed_pkg::FED_OP_UNHANDLED;
        endcase
      end else begin
        // Register forms: first-byte low bits and the whole second byte.
        casez ({w[10:8], w[7:0]})
          11'b00111000???: d.op = fed_pkg::FED_OP_LOAD_REG; // see RL9
          11'b00111001???: d.op = fed_pkg::FED_OP_SWAP; // see RL9
          11'b10111010???: d.op = fed_pkg::FED_OP_STORE_REG; // see RL10
          11'b10111011???: d.op = fed_pkg::FED_OP_STORE_POP_REG; // see RL10
          11'b00011010???: d.op = fed_pkg::FED_OP_CMP_REG; // see RL11
          11'b00011011???: d.op = fed_pkg::FED_OP_CMP_POP_REG; // see RL11
          11'b11011011001: d.op = fed_pkg::FED_OP_CMP_POP2; // see RL12
          11'b00111100100: d.op = fed_pkg::FED_OP_TEST_ZERO; // see RL12
          11'b00111100101: d.op = fed_pkg::FED_OP_CLASSIFY; // see RL12
          11'b10111100???: d.op = fed_pkg::FED_OP_UCMP; // see RL13
          11'b10111101???: d.op = fed_pkg::FED_OP_UCMP_POP; // see RL13
          11'b01011101001: d.op = fed_pkg::FED_OP_UCMP_POP2; // see RL13
          default: d.op = fed_pkg::FED_OP_UNHANDLED;
        endcase
      end
    end
    // Escape words outside the table are flagged unhandled.
    d.unhandled = ~d.not_escape &
      (d.op == fed_pkg::FED_OP_UNHANDLED); // see RL17
    // Only subtract and divide, left unhandled here, carry the swap
    // flag; the unordered pop-twice word shares their bit pattern.
    d.reverse = subdiv & d.unhandled & (w[3] ^ d.target); // see RL4
    // Number of stack pops that the operation implies.
    case (d.op)
      fed_pkg::FED_OP_STORE_POP_MEM, fed_pkg::FED_OP_STORE_INT64,
      fed_pkg::FED_OP_STORE_REAL80, fed_pkg::FED_OP_STORE_BCD,
      fed_pkg::FED_OP_STORE_POP_REG, fed_pkg::FED_OP_CMP_POP_MEM,
      fed_pkg::FED_OP_CMP_POP_REG, fed_pkg::FED_OP_UCMP_POP: begin
        d.pops = 2'h1;
      end
      fed_pkg::FED_OP_CMP_POP2, fed_pkg::FED_OP_UCMP_POP2: begin
        d.pops = 2'h2;
      end
      default: begin
        d.pops = 2'h0;
      end
    endcase
    // Index byte and offset bytes follow the host's 32-bit addressing.
    has_sib = ~is_reg & (w[2:0] == fed_pkg::FED_RM_SIB); // see RL8
    if (w[7:6] == fed_pkg::FED_MOD_DISP8) begin
      offset_bytes = fed_pkg::FED_LEN_DISP8; // see RL8
    end else if (w[7:6] == fed_pkg::FED_MOD_DISP32) begin
      offset_bytes = fed_pkg::FED_LEN_DISP32; // see RL8
    end else if (w[7:6] == fed_pkg::FED_MOD_NODISP &&
                 (w[2:0] == fed_pkg::FED_RM_DIRECT ||
                  (has_sib && w[18:16] == fed_pkg::FED_SIB_NO_BASE))) begin
      offset_bytes = fed_pkg::FED_LEN_DISP32; // see RL8
    end else begin
      offset_bytes = 3'h0;
    end
    d.length = 3'(fed_pkg::FED_LEN_BASE + {2'h0, has_sib} + offset_bytes); // see RL8
    // Both a base and an index register are in use.
    d.base_index = has_sib & (w[21:19] != fed_pkg::FED_SIB_NO_INDEX) &
      ~(w[7:6] == fed_pkg::FED_MOD_NODISP &&
        w[18:16] == fed_pkg::FED_SIB_NO_BASE); // see RL14
    // Zero is flagged by software; the decoder cannot see the operand.
    zero_load = zero_hint & (d.op == fed_pkg::FED_OP_LOAD_MEM) & ~w[9];
    d.extra = 3'((d.base_index ? fed_pkg::FED_EXTRA_BASE_INDEX : 3'h0) +
      (zero_load ? fed_pkg::FED_EXTRA_ZERO_LOAD : 3'h0)); // see RL14 RL15
    return d;
  endfunction

  // Transfer completion and the word write strobe.
  assign acc_w = apb_req.psel & apb_req.penable & st_ff.rsp.pready;
  assign wr_word_w = acc_w & apb_req.pwrite &
    (apb_req.paddr == fed_pkg::FED_OFS_WORD);

  // Next state: bus answer, register writes and the decode itself.
  always_comb begin
    nxt_st = st_ff;
    // One wait state: ready rises in the second access cycle.
    nxt_st.rsp.pready = apb_req.psel & apb_req.penable &
      ~st_ff.rsp.pready;
    nxt_st.rsp.pslverr = 1'b0;
    nxt_st.rsp.prdata = 32'h0000_0000;
    nxt_st.dec.valid = 1'b0;
    if (apb_req.psel && apb_req.penable && !st_ff.rsp.pready) begin
      // Answer prepared now, shown with ready on the next cycle.
      case (apb_req.paddr)
        fed_pkg::FED_OFS_WORD: begin
          nxt_st.rsp.prdata = st_ff.word;
        end
        fed_pkg::FED_OFS_CTRL: begin
          nxt_st.rsp.prdata = {31'h0, st_ff.zero_hint};
        end
        fed_pkg::FED_OFS_RESULT: begin
          // The result register cannot be written.
          nxt_st.rsp.prdata = {2'h0, st_ff.dec};
          nxt_st.rsp.pslverr = apb_req.pwrite;
        end
        default: begin
          // Unmapped addresses answer with an error.
          nxt_st.rsp.pslverr = 1'b1;
        end
      endcase
    end
    if (acc_w && apb_req.pwrite &&
        apb_req.paddr == fed_pkg::FED_OFS_CTRL) begin
      nxt_st.zero_hint = apb_req.pwdata[fed_pkg::FED_CTRL_ZERO_BIT];
    end
    if (wr_word_w) begin
      // Decoded fields leave at the same edge the word is taken.
      nxt_st.word = apb_req.pwdata;
      nxt_st.dec = decode_word(apb_req.pwdata, st_ff.zero_hint); // see RL16
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff <= '{word: fed_pkg::FED_WORD_RST,
                 zero_hint: fed_pkg::FED_ZERO_HINT_RST,
                 dec: '0, rsp: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs come straight from the state register.
  assign apb_rsp = st_ff.rsp;
  assign dec_out = st_ff.dec;

  // Checks on the decoder, one clock domain.
  a_esc_prefix: assert property ( // see RL1
    wr_word_w |=> dec_out.valid && (dec_out.not_escape ==
      ($past(apb_req.pwdata[15:11]) != fed_pkg::FED_ESC_PREFIX)))
    else $error("escape prefix check wrong");
  // Foreign words are neither decoded nor flagged as ours.
  a_foreign_word: assert property ( // see RL1 RL17
    dec_out.valid && dec_out.not_escape
    |-> !dec_out.unhandled && dec_out.op == fed_pkg::FED_OP_UNHANDLED)
    else $error("foreign word decoded");
  a_mem_format: assert property ( // see RL2
    wr_word_w |=> dec_out.mf == $past(apb_req.pwdata[10:9]))
    else $error("memory format not passed on");
  a_target_choice: assert property ( // see RL3
    wr_word_w && apb_req.pwdata[7:6] == fed_pkg::FED_MOD_REG
    |=> dec_out.target == $past(apb_req.pwdata[10]))
    else $error("target choice wrong");
  // Memory forms always leave the result on the top, with no unwind.
  a_target_memory: assert property ( // see RL3 RL5
    wr_word_w && apb_req.pwdata[7:6] != fed_pkg::FED_MOD_REG
    |=> !dec_out.target && !dec_out.unwind)
    else $error("memory form target not top");
  a_swap_order: assert property ( // see RL4
    wr_word_w && apb_req.pwdata[15:11] == fed_pkg::FED_ESC_PREFIX &&
    !apb_req.pwdata[8] && apb_req.pwdata[7:5] == 3'h7 &&
    apb_req.pwdata[10:0] != 11'h2e9
    |=> dec_out.reverse ==
      ($past(apb_req.pwdata[3]) ^ $past(apb_req.pwdata[10])))
    else $error("operand order wrong");
  // In memory forms the swap bit alone sets the order.
  a_swap_memory: assert property ( // see RL4
    wr_word_w && apb_req.pwdata[15:11] == fed_pkg::FED_ESC_PREFIX &&
    !apb_req.pwdata[8] && apb_req.pwdata[5] &&
    apb_req.pwdata[7:6] != fed_pkg::FED_MOD_REG
    |=> dec_out.reverse == $past(apb_req.pwdata[3]))
    else $error("memory operand order wrong");
  // Decoded operations are never subtract or divide.
  a_swap_quiet: assert property ( // see RL4
    dec_out.valid && dec_out.op != fed_pkg::FED_OP_UNHANDLED
    |-> !dec_out.reverse)
    else $error("swap flag on a decoded operation");
  a_unwind_slot: assert property ( // see RL5 RL6
    wr_word_w && apb_req.pwdata[7:6] == fed_pkg::FED_MOD_REG
    |=> dec_out.unwind == $past(apb_req.pwdata[9]) &&
      dec_out.slot == $past(apb_req.pwdata[2:0]))
    else $error("unwind or slot wrong");
  a_mode_passed: assert property ( // see RL7
    wr_word_w |=> dec_out.mode == $past(apb_req.pwdata[7:6]) &&
      dec_out.rm == $past(apb_req.pwdata[2:0]))
    else $error("addressing fields not passed on");
  a_length_calc: assert property ( // see RL8
    wr_word_w && apb_req.pwdata[7:6] == fed_pkg::FED_MOD_DISP8 &&
    apb_req.pwdata[2:0] == fed_pkg::FED_RM_SIB
    |=> dec_out.length == 3'h4)
    else $error("length with index byte wrong");
  // A direct address brings four offset bytes and no index byte.
  a_length_direct: assert property ( // see RL8
    wr_word_w && apb_req.pwdata[7:6] == fed_pkg::FED_MOD_NODISP &&
    apb_req.pwdata[2:0] == fed_pkg::FED_RM_DIRECT
    |=> dec_out.length == 3'h6)
    else $error("direct address length wrong");
  // Register forms are exactly two bytes.
  a_length_reg: assert property ( // see RL8
    wr_word_w && apb_req.pwdata[7:6] == fed_pkg::FED_MOD_REG
    |=> dec_out.length == 3'h2 && !dec_out.base_index)
    else $error("register form length wrong");
  a_load_decode: assert property ( // see RL9
    wr_word_w && apb_req.pwdata[15:8] == 8'hdf &&
    apb_req.pwdata[7:6] != fed_pkg::FED_MOD_REG &&
    apb_req.pwdata[5:3] == 3'h5
    |=> dec_out.op == fed_pkg::FED_OP_LOAD_INT64)
    else $error("long integer load missed");
  // Register load and the exchange differ in one bit.
  a_load_reg: assert property ( // see RL9
    wr_word_w && apb_req.pwdata[15:8] == 8'hd9 &&
    apb_req.pwdata[7:4] == 4'hc
    |=> dec_out.op == ($past(apb_req.pwdata[3]) ?
      fed_pkg::FED_OP_SWAP : fed_pkg::FED_OP_LOAD_REG))
    else $error("register load or exchange missed");
  a_store_decode: assert property ( // see RL10
    wr_word_w && apb_req.pwdata[15:8] == 8'hdd &&
    apb_req.pwdata[7:3] == 5'h1b
    |=> dec_out.op == fed_pkg::FED_OP_STORE_POP_REG &&
      dec_out.pops == 2'h1)
    else $error("register store-pop missed");
  // The packed decimal store always pops.
  a_store_bcd: assert property ( // see RL10
    wr_word_w && apb_req.pwdata[15:8] == 8'hdf &&
    apb_req.pwdata[7:6] != fed_pkg::FED_MOD_REG &&
    apb_req.pwdata[5:3] == 3'h6
    |=> dec_out.op == fed_pkg::FED_OP_STORE_BCD && dec_out.pops == 2'h1)
    else $error("decimal store missed");
  a_compare_decode: assert property ( // see RL11
    wr_word_w && apb_req.pwdata[15:8] == 8'hd8 &&
    apb_req.pwdata[7:3] == 5'h1a
    |=> dec_out.op == fed_pkg::FED_OP_CMP_REG)
    else $error("register compare missed");
  // Memory compare-and-pop in any format.
  a_compare_mem: assert property ( // see RL11
    wr_word_w && apb_req.pwdata[15:11] == fed_pkg::FED_ESC_PREFIX &&
    !apb_req.pwdata[8] && apb_req.pwdata[5:3] == 3'h3 &&
    apb_req.pwdata[7:6] != fed_pkg::FED_MOD_REG
    |=> dec_out.op == fed_pkg::FED_OP_CMP_POP_MEM && dec_out.pops == 2'h1)
    else $error("memory compare-pop missed");
  a_fixed_decode: assert property ( // see RL12
    wr_word_w && apb_req.pwdata[15:0] == 16'hded9
    |=> dec_out.op == fed_pkg::FED_OP_CMP_POP2 &&
      dec_out.pops == 2'h2)
    else $error("compare pop twice missed");
  // Zero test and classify are one fixed word each.
  a_fixed_test: assert property ( // see RL12
    wr_word_w && apb_req.pwdata[15:1] == 15'h6cf2
    |=> dec_out.op == ($past(apb_req.pwdata[0]) ?
      fed_pkg::FED_OP_CLASSIFY : fed_pkg::FED_OP_TEST_ZERO))
    else $error("test or classify missed");
  a_unord_decode: assert property ( // see RL13
    wr_word_w && apb_req.pwdata[15:0] == 16'hdae9
    |=> dec_out.op == fed_pkg::FED_OP_UCMP_POP2)
    else $error("unordered pop twice missed");
  // Unordered compare with and without a pop, any slot.
  a_unord_slot: assert property ( // see RL13
    wr_word_w && apb_req.pwdata[15:8] == 8'hdd &&
    apb_req.pwdata[7:4] == 4'he
    |=> dec_out.op == ($past(apb_req.pwdata[3]) ?
      fed_pkg::FED_OP_UCMP_POP : fed_pkg::FED_OP_UCMP))
    else $error("unordered compare missed");
  a_base_index: assert property ( // see RL14
    dec_out.valid && dec_out.base_index &&
    dec_out.op != fed_pkg::FED_OP_LOAD_MEM
    |-> dec_out.extra == 3'h1)
    else $error("base plus index clock missing");
  a_zero_load: assert property ( // see RL15
    dec_out.valid && dec_out.op == fed_pkg::FED_OP_LOAD_MEM &&
    !dec_out.mf[0] && !dec_out.base_index && st_ff.zero_hint
    |-> dec_out.extra == 3'h5)
    else $error("zero load clocks missing");
  // Integer formats never earn the zero-load clocks.
  a_zero_int: assert property ( // see RL15
    dec_out.valid && dec_out.mf[0] && !dec_out.base_index
    |-> dec_out.extra == 3'h0)
    else $error("zero clocks on an integer load");
  a_valid_pulse: assert property ( // see RL16
    wr_word_w |=> dec_out.valid ##1 !dec_out.valid)
    else $error("decode valid not a single pulse");
  // Ready stands one cycle, so each word is taken once.
  a_ready_pulse: assert property ( // see RL16
    apb_rsp.pready |=> !apb_rsp.pready)
    else $error("ready held longer than one cycle");
  a_unhandled_flag: assert property ( // see RL17
    dec_out.valid && dec_out.unhandled
    |-> !dec_out.not_escape &&
      dec_out.op == fed_pkg::FED_OP_UNHANDLED)
    else $error("unhandled flag wrong");

endmodule // fed_decoder
`default_nettype wire

// ===== testbench/fed_host.sv
`timescale 1ns/10ps
`default_nettype none
// Host-side APB master; the bench calls it just after a rising edge.
module fed_host (
  input wire logic clk,
  output fed_pkg::fed_apb_req_t apb_req,
  input wire fed_pkg::fed_apb_rsp_t apb_rsp
);
  // The bus is idle at time zero.
  initial begin
    apb_req = '0;
  end

  // One transfer, held until pready is high at a rising edge.
  task automatic xfer(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] rd, output logic err);
    apb_req.psel <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite <= wr;
    apb_req.paddr <= a;
    apb_req.pwdata <= d;
    @(posedge clk);
    apb_req.penable <= 1'b1;
    // Read just after an edge, the answer holds what that edge sampled.
    do @(posedge clk); while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    // Released data shows the inverse, so a stale copy never matches.
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    apb_req.pwdata <= ~d;
  endtask
endmodule // fed_host
`default_nettype wire

// ===== testbench/fpu_escape_opcode_decoder_test.sv
`timescale 1ns/10ps
`default_nettype none
// Self-checking bench: corner words first, then seeded random words.
module fpu_escape_opcode_decoder_test;
  logic clk = 1'b0; // The 20 MHz clock.
  logic srst = 1'b1; // Reset is held at the start.
  fed_pkg::fed_apb_req_t apb_req;
  fed_pkg::fed_apb_rsp_t apb_rsp;
  fed_pkg::fed_dec_t dec_out;
  int failures = 0;
  int tests_run = 0;
  int seed = 32'hac27;
  logic hint = 1'b0; // Mirror of the zero-operand hint.
  logic [31:0] rd;
  logic err;
  logic [31:0] r;
  logic [31:0] w;
  // Fixed encodings, slot seven, addressing extremes, a foreign word.
  logic [31:0] corner [12] = '{32'h0000d9e4, 32'h0000d9e5, 32'h0000ded9,
    32'h0000dae9, 32'h0000d905, 32'h0000db05, 32'h0000dd05, 32'h000ad944,
    32'h0022d944, 32'h000dd904, 32'h0000dddf, 32'h00001234};

  always #25 clk = ~clk;

  fed_decoder dut_u (.clk(clk), .srst(srst), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .dec_out(dec_out));
  fed_host host_u (.clk(clk), .apb_req(apb_req), .apb_rsp(apb_rsp));

  // Works out the decode from the word; m marks the bits to trust.
  function automatic void expect_dec(input logic [31:0] w, input logic h,
      output fed_pkg::fed_dec_t e, output logic [29:0] m);
    logic rf;
    logic scaled_index_byte;
    logic [2:0] dsp;
    rf = (w[7:6] == 2'h3);
    e = '0;
    m = 30'h3ff00000;
    e.valid = 1'b1;
    e.mf = w[10:9];
    e.not_escape = (w[15:11] != 5'h1b);
    if (e.not_escape) return;
    m = 30'h3fffffff;
    if (!rf && w[5:3] == 3'h0 && w[8]) e.op = fed_pkg::FED_OP_LOAD_MEM;
    if (!rf && w[5:3] == 3'h2) e.op = w[8] ? fed_pkg::FED_OP_STORE_MEM :
      fed_pkg::FED_OP_CMP_MEM;
    if (!rf && w[5:3] == 3'h3) e.op = w[8] ?
      fed_pkg::FED_OP_STORE_POP_MEM : fed_pkg::FED_OP_CMP_POP_MEM;
    if (!rf) begin
      case ({w[10:8], w[5:3]})
        6'h3d: e.op = fed_pkg::FED_OP_LOAD_INT64;
        6'h1d: e.op = fed_pkg::FED_OP_LOAD_REAL80;
        6'h3c: e.op = fed_pkg::FED_OP_LOAD_BCD;
        6'h3f: e.op = fed_pkg::FED_OP_STORE_INT64;
        6'h1f: e.op = fed_pkg::FED_OP_STORE_REAL80;
        6'h3e: e.op = fed_pkg::FED_OP_STORE_BCD;
        default: ;
      endcase
    end else begin
      case ({w[10:8], w[7:3]})
        8'h38: e.op = fed_pkg::FED_OP_LOAD_REG;
        8'h39: e.op = fed_pkg::FED_OP_SWAP;
        8'hba: e.op = fed_pkg::FED_OP_STORE_REG;
        8'hbb: e.op = fed_pkg::FED_OP_STORE_POP_REG;
        8'hbc: e.op = fed_pkg::FED_OP_UCMP;
        8'hbd: e.op = fed_pkg::FED_OP_UCMP_POP;
        8'h1a: e.op = fed_pkg::FED_OP_CMP_REG;
        8'h1b: e.op = fed_pkg::FED_OP_CMP_POP_REG;
        default: ;
      endcase
      case (w[10:0])
        11'h1e4: e.op = fed_pkg::FED_OP_TEST_ZERO;
        11'h1e5: e.op = fed_pkg::FED_OP_CLASSIFY;
        11'h6d9: e.op = fed_pkg::FED_OP_CMP_POP2;
        11'h2e9: e.op = fed_pkg::FED_OP_UCMP_POP2;
        default: ;
      endcase
    end
    case (e.op)
      fed_pkg::FED_OP_CMP_POP2, fed_pkg::FED_OP_UCMP_POP2: e.pops = 2'h2;
      fed_pkg::FED_OP_STORE_POP_MEM, fed_pkg::FED_OP_STORE_INT64,
      fed_pkg::FED_OP_STORE_REAL80, fed_pkg::FED_OP_STORE_BCD,
      fed_pkg::FED_OP_STORE_POP_REG, fed_pkg::FED_OP_CMP_POP_MEM,
      fed_pkg::FED_OP_CMP_POP_REG, fed_pkg::FED_OP_UCMP_POP: e.pops = 2'h1;
      default: e.pops = 2'h0;
    endcase
    e.unhandled = (e.op == fed_pkg::FED_OP_UNHANDLED);
    // Pops of foreign escape words are not ours to judge.
    if (e.unhandled) m[13:12] = 2'h0;
    // Subtract and divide stay unhandled but still carry the swap flag.
    if (e.unhandled && !w[8] && (rf ? w[7:5] == 3'h7 : w[5]))
      e.reverse = w[3] ^ (rf & w[10]);
    e.target = rf & w[10];
    e.unwind = rf & w[9];
    e.slot = rf ? w[2:0] : 3'h0;
    e.mode = w[7:6];
    e.rm = w[2:0];
    scaled_index_byte = !rf && (w[2:0] == 3'h4);
    dsp = (w[7:6] == 2'h1) ? 3'h1 : 3'h0;
    if (w[7:6] == 2'h2 || (w[7:6] == 2'h0 && (w[2:0] == 3'h5 ||
        (scaled_index_byte && w[18:16] == 3'h5)))) dsp = 3'h4;
    e.length = 3'h2 + {2'h0, scaled_index_byte} + dsp;
    e.base_index = scaled_index_byte && w[21:19] != 3'h4 &&
      !(w[7:6] == 2'h0 && w[18:16] == 3'h5);
    e.extra = {2'h0, e.base_index};
    if (e.op == fed_pkg::FED_OP_LOAD_MEM && !w[9] && h)
      e.extra = e.extra + 3'h5;
  endfunction

  // Compare of one bus word.
  task automatic cmp_word(input string n, input logic [31:0] x,
      input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask

  // Compare of one flag.
  task automatic cmp_bit(input string n, input logic x, input logic g);
    tests_run++;
    if (g !== x) begin
      failures++;
      $display("[ERR] %s expected %b seen %b", n, x, g);
    end
  endtask

  // Compare of a decode record under a mask.
  task automatic cmp_dec(input string n, input logic [29:0] x,
      input logic [29:0] g, input logic [29:0] m);
    tests_run++;
    if (((x ^ g) & m) !== 30'h0) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, x & m, g & m);
    end
  endtask

  // Register read with expected data and error flag.
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x,
      input logic xe);
    @(posedge clk);
    host_u.xfer(1'b0, a, 32'h0, rd, err);
    cmp_word("prdata", x, rd);
    cmp_bit("pslverr", xe, err);
  endtask

  // Register write with expected error flag.
  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d,
      input logic xe);
    @(posedge clk);
    host_u.xfer(1'b1, a, d, rd, err);
    cmp_bit("pslverr", xe, err);
  endtask

  // Hint writes also update the mirror used for expectations.
  task automatic set_hint(input logic v);
    wr_chk(fed_pkg::FED_OFS_CTRL, {31'h0, v}, 1'b0);
    hint = v;
  endtask

  // One word: decode on the next cycle, one-cycle valid, then readback.
  task automatic send_word(input logic [31:0] x);
    fed_pkg::fed_dec_t e;
    logic [29:0] m;
    expect_dec(x, hint, e, m);
    wr_chk(fed_pkg::FED_OFS_WORD, x, 1'b0);
    @(negedge clk);
    cmp_dec("dec_out", e, dec_out, m);
    @(negedge clk);
    cmp_bit("valid", 1'b0, dec_out.valid);
    e.valid = 1'b0;
    rd_chk(fed_pkg::FED_OFS_WORD, x, 1'b0);
    @(posedge clk);
    host_u.xfer(1'b0, fed_pkg::FED_OFS_RESULT, 32'h0, rd, err);
    cmp_dec("result", e, rd[29:0], m);
  endtask

  // Ends the run in one place with the verdict.
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Cuts a hang short; a normal run needs well under a third of this.
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    finish_test;
  end

  // Reset, register map, corner words, random words, second reset.
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    rd_chk(fed_pkg::FED_OFS_WORD, 32'h0, 1'b0);
    rd_chk(fed_pkg::FED_OFS_CTRL, 32'h0, 1'b0);
    set_hint(1'b1);
    rd_chk(fed_pkg::FED_OFS_CTRL, 32'h1, 1'b0);
    wr_chk(fed_pkg::FED_OFS_RESULT, 32'hffff_ffff, 1'b1);
    rd_chk(8'h0c, 32'h0, 1'b1);
    foreach (corner[i]) send_word(corner[i]);
    for (int i = 0; i < 300; i++) begin
      r = $random(seed);
      w = $random(seed);
      if (r[3:0] != 4'h0) w[15:11] = 5'h1b;
      if (r[4]) w[7:3] = {2'h3, r[7:5]};
      if (r[11:8] == 4'h0) set_hint(r[12]);
      send_word(w);
    end
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    hint = 1'b0;
    rd_chk(fed_pkg::FED_OFS_WORD, 32'h0, 1'b0);
    rd_chk(fed_pkg::FED_OFS_CTRL, 32'h0, 1'b0);
    send_word(32'h0000d905);
    finish_test;
  end
endmodule // fpu_escape_opcode_decoder_test
`default_nettype wire
